//--- rtl/hdu_cfg.svh
// Purpose: offsets, field positions, reset values of the half-duplex channel
// Assumes: 8-bit register port, 3-bit word index
// Notes: none
`ifndef HDU_CFG_SVH
`define HDU_CFG_SVH
`define HDU_SETUP_ADDR 3'h0
`define HDU_FORMAT_ADDR 3'h1
`define HDU_BAUD_LO_ADDR 3'h2
`define HDU_BAUD_HI_ADDR 3'h3
`define HDU_CTRL_ADDR 3'h4
`define HDU_BUF_ADDR 3'h5
`define HDU_STAT_ADDR 3'h6
`define HDU_DIR_BIT 0
`define HDU_RSEL_BIT 1
`define HDU_RSS_BIT 2
`define HDU_CKS_LSB 4
`define HDU_LEN_LSB 0
`define HDU_PEN_BIT 2
`define HDU_PODD_BIT 3
`define HDU_STOP2_BIT 4
`define HDU_MSB_BIT 5
`define HDU_NEG_BIT 6
`define HDU_RUN_BIT 0
`define HDU_FER_BIT 0
`define HDU_OER_BIT 1
`define HDU_PER_BIT 2
`define HDU_FULL_BIT 3
`define HDU_BAUD_RST 12'hfff
`define HDU_BYTE_RST 8'h00
`endif

//--- rtl/hdu_pkg.sv
// Purpose: state types of the half-duplex channel
// Assumes: nothing
// Notes: none
package hdu_pkg;
  typedef enum logic [2:0] {
    tx_idle = 3'h0, tx_start = 3'h1, tx_data = 3'h2, tx_par = 3'h3, tx_stop = 3'h4
  } hdu_tx_state_type;
  typedef enum logic [2:0] {
    rx_idle = 3'h0, rx_start = 3'h1, rx_data = 3'h2, rx_par = 3'h3, rx_stop = 3'h4
  } hdu_rx_state_type;
endpackage

//--- rtl/hdu_baud.sv
// Purpose: baud generator making bit-boundary and mid-bit pulses
// Assumes: tick is a one-cycle enable from the clock selector
// Notes: mid point moves one tick later when late is set
`timescale 1ns/1ps
module hdu_baud #(
  parameter int CW = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic restart,
  input wire logic [CW-1:0] limit,
  input wire logic late,
  output logic fall_edge,
  output logic rise_edge
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] mid;

  if (CW < 2) begin : g_chk
    $error("hdu_baud needs CW of at least 2");
  end

  assign mid = (limit >> 1) + {{(CW-1){1'b0}}, late};

  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= (cnt == limit) ? '0 : cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      fall_edge <= 1'b0;
      rise_edge <= 1'b0;
    end else begin
      fall_edge <= tick && (cnt == limit);
      rise_edge <= tick && (cnt == mid);
    end
  end

  a_restart_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    restart |=> !fall_edge && !rise_edge)
    else $error("transfer clock edge right after restart");
endmodule

//--- rtl/hdu_channel.sv
// Purpose: one half-duplex asynchronous serial channel with register port
// Assumes: bus master per plain strobe port, pins asynchronous to ref_clk
// Notes: irq_req is a one-cycle request pulse
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`include "hdu_cfg.svh"
module hdu_channel (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic serial_in_pin0,
  input wire logic serial_in_pin1,
  output logic serial_out_pin,
  output logic irq_req
);
  logic direction_select, rx_pin_select, sample_shift_select;
  logic [1:0] baud_clk_sel;
  logic [1:0] len_code;
  logic par_en, par_odd, stop2, msb_first, neg;
  logic [11:0] baud_count;
  logic channel_run;
  logic [7:0] shared_data_buffer;
  logic buffer_full_flag, parity_error_flag, overrun_error_flag, frame_error_flag;
  logic unread;
  logic [2:0] pre;
  logic src_tick;
  logic in0_s1, in0_s2, in1_s1, in1_s2;
  logic rx_line;
  logic rx_prev;
  logic bit_fall, bit_rise;
  logic [2:0] last_idx;
  logic wr_setup, wr_format, wr_lo, wr_hi, wr_ctrl, wr_buf, wr_stat, rd_buf;
  hdu_pkg::hdu_tx_state_type tx_state;
  hdu_pkg::hdu_rx_state_type rx_state;
  logic [2:0] tx_idx, rx_idx;
  logic tx_second, rx_second;
  logic [7:0] tx_shift, rx_word;
  logic tx_go, tx_end, tx_load, tx_done, tx_bit;
  logic rx_detect, rx_fetch, rx_check, rx_check2;
  logic rx_start_err, rx_par_bit;
  logic [7:0] stat_val;
  logic [7:0] next_rdata;

  function automatic logic [7:0] len_mask(input logic [1:0] lc);
    len_mask = 8'hff >> (2'd3 - lc);
  endfunction

  function automatic logic par_of(input logic [7:0] w, input logic [1:0] lc,
                                  input logic odd);
    par_of = (^(w & len_mask(lc))) ^ odd;
  endfunction

  function automatic logic [2:0] pick(input logic [2:0] idx, input logic [2:0] last,
                                      input logic msb);
    pick = msb ? last - idx : idx;
  endfunction

  assign wr_setup = reg_wr && (reg_addr == `HDU_SETUP_ADDR);
  assign wr_format = reg_wr && (reg_addr == `HDU_FORMAT_ADDR);
  assign wr_lo = reg_wr && (reg_addr == `HDU_BAUD_LO_ADDR);
  assign wr_hi = reg_wr && (reg_addr == `HDU_BAUD_HI_ADDR);
  assign wr_ctrl = reg_wr && (reg_addr == `HDU_CTRL_ADDR);
  assign wr_buf = reg_wr && (reg_addr == `HDU_BUF_ADDR);
  assign wr_stat = reg_wr && (reg_addr == `HDU_STAT_ADDR);
  assign rd_buf = reg_rd && (reg_addr == `HDU_BUF_ADDR);
  assign last_idx = 3'd4 + {1'b0, len_code};

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      direction_select <= 1'b0;
      rx_pin_select <= 1'b0;
      sample_shift_select <= 1'b0;
      baud_clk_sel <= 2'h0;
    end else if (wr_setup) begin
      direction_select <= reg_wdata[`HDU_DIR_BIT];
      rx_pin_select <= reg_wdata[`HDU_RSEL_BIT];
      sample_shift_select <= reg_wdata[`HDU_RSS_BIT];
      baud_clk_sel <= reg_wdata[`HDU_CKS_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      len_code <= 2'h0;
      par_en <= 1'b0;
      par_odd <= 1'b0;
      stop2 <= 1'b0;
      msb_first <= 1'b0;
      neg <= 1'b0;
    end else if (wr_format) begin
      len_code <= reg_wdata[`HDU_LEN_LSB +: 2];
      par_en <= reg_wdata[`HDU_PEN_BIT];
      par_odd <= reg_wdata[`HDU_PODD_BIT];
      stop2 <= reg_wdata[`HDU_STOP2_BIT];
      msb_first <= reg_wdata[`HDU_MSB_BIT];
      neg <= reg_wdata[`HDU_NEG_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      baud_count <= `HDU_BAUD_RST;
    end else if (wr_lo) begin
      baud_count[7:0] <= reg_wdata;
    end else if (wr_hi) begin
      baud_count[11:8] <= reg_wdata[3:0];
    end
  end

  // hardware clear on transmit end; software write wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      channel_run <= 1'b0;
    end else if (wr_ctrl) begin
      channel_run <= reg_wdata[`HDU_RUN_BIT];
    end else if (tx_done) begin
      channel_run <= 1'b0;
    end
  end

  // generator clock select: ref_clk divided by 1, 2, 4 or 8
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre <= 3'h0;
    end else begin
      pre <= pre + 3'h1;
    end
  end

  always_comb begin
    unique case (baud_clk_sel)
      2'h0: src_tick = 1'b1;
      2'h1: src_tick = pre[0];
      2'h2: src_tick = &pre[1:0];
      2'h3: src_tick = &pre;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in0_s1 <= 1'b1;
      in0_s2 <= 1'b1;
      in1_s1 <= 1'b1;
      in1_s2 <= 1'b1;
    end else begin
      in0_s1 <= serial_in_pin0;
      in0_s2 <= in0_s1;
      in1_s1 <= serial_in_pin1;
      in1_s2 <= in1_s1;
    end
  end

  // line in mark-high sense
  assign rx_line = (rx_pin_select ? in1_s2 : in0_s2) ^ neg;

  hdu_baud #(.CW(12)) u_baud (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(src_tick),
    .restart(tx_go || rx_detect),
    .limit(baud_count),
    .late(sample_shift_select),
    .fall_edge(bit_fall),
    .rise_edge(bit_rise)
  );

  // transmitter
  assign tx_go = channel_run && !direction_select && (tx_state == hdu_pkg::tx_idle);
  assign tx_end = bit_fall && (tx_state == hdu_pkg::tx_stop) && (!stop2 || tx_second);
  assign tx_load = tx_go || (tx_end && buffer_full_flag);
  assign tx_done = tx_end && !buffer_full_flag;

  always_ff @(posedge ref_clk) begin
    if (rst || direction_select || !channel_run) begin
      tx_state <= hdu_pkg::tx_idle;
      tx_idx <= 3'h0;
      tx_second <= 1'b0;
    end else if (tx_load) begin
      tx_state <= hdu_pkg::tx_start;
      tx_shift <= shared_data_buffer;
      tx_second <= 1'b0;
    end else if (tx_done) begin
      tx_state <= hdu_pkg::tx_idle;
    end else if (bit_fall) begin
      unique case (tx_state)
        hdu_pkg::tx_start: begin
          tx_state <= hdu_pkg::tx_data;
          tx_idx <= 3'h0;
        end
        hdu_pkg::tx_data: begin
          if (tx_idx == last_idx) begin
            tx_state <= par_en ? hdu_pkg::tx_par : hdu_pkg::tx_stop;
          end else begin
            tx_idx <= tx_idx + 3'h1;
          end
        end
        hdu_pkg::tx_par: tx_state <= hdu_pkg::tx_stop;
        hdu_pkg::tx_stop: tx_second <= 1'b1;
        hdu_pkg::tx_idle: tx_state <= hdu_pkg::tx_idle;
        default: tx_state <= hdu_pkg::tx_idle;
      endcase
    end
  end

  always_comb begin
    unique case (tx_state)
      hdu_pkg::tx_start: tx_bit = 1'b0;
      hdu_pkg::tx_data: tx_bit = tx_shift[pick(tx_idx, last_idx, msb_first)];
      hdu_pkg::tx_par: tx_bit = par_of(tx_shift, len_code, par_odd);
      default: tx_bit = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serial_out_pin <= 1'b1;
    end else if (direction_select) begin
      serial_out_pin <= 1'b1;
    end else begin
      serial_out_pin <= tx_bit ^ neg;
    end
  end

  // line level at the previous tick; a start needs a falling edge, not a low level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_prev <= 1'b0;
    end else if (src_tick) begin
      rx_prev <= rx_line;
    end
  end

  // receiver
  assign rx_detect = channel_run && direction_select && (rx_state == hdu_pkg::rx_idle)
                     && src_tick && rx_prev && !rx_line;
  assign rx_fetch = bit_fall && (((rx_state == hdu_pkg::rx_data) && (rx_idx == last_idx)
                    && !par_en) || (rx_state == hdu_pkg::rx_par));
  assign rx_check = bit_rise && (rx_state == hdu_pkg::rx_stop) && !rx_second;
  assign rx_check2 = bit_rise && (rx_state == hdu_pkg::rx_stop) && rx_second;

  always_ff @(posedge ref_clk) begin
    if (rst || !channel_run || !direction_select) begin
      rx_state <= hdu_pkg::rx_idle;
      rx_second <= 1'b0;
    end else if (rx_detect) begin
      rx_state <= hdu_pkg::rx_start;
      rx_word <= 8'h00;
      rx_start_err <= 1'b0;
      rx_second <= 1'b0;
      rx_idx <= 3'h0;
    end else begin
      if (bit_rise) begin
        if (rx_state == hdu_pkg::rx_start) begin
          rx_start_err <= rx_line;
        end else if (rx_state == hdu_pkg::rx_data) begin
          rx_word[pick(rx_idx, last_idx, msb_first)] <= rx_line;
        end else if (rx_state == hdu_pkg::rx_par) begin
          rx_par_bit <= rx_line;
        end else if (rx_state == hdu_pkg::rx_stop) begin
          if (!stop2 || rx_second) begin
            rx_state <= hdu_pkg::rx_idle;
          end else begin
            rx_second <= 1'b1;
          end
        end
      end
      if (bit_fall) begin
        if (rx_state == hdu_pkg::rx_start) begin
          rx_state <= hdu_pkg::rx_data;
          rx_idx <= 3'h0;
        end else if (rx_state == hdu_pkg::rx_data) begin
          if (rx_idx == last_idx) begin
            rx_state <= par_en ? hdu_pkg::rx_par : hdu_pkg::rx_stop;
          end else begin
            rx_idx <= rx_idx + 3'h1;
          end
        end else if (rx_state == hdu_pkg::rx_par) begin
          rx_state <= hdu_pkg::rx_stop;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shared_data_buffer <= `HDU_BYTE_RST;
    end else if (rx_fetch) begin
      shared_data_buffer <= rx_word & len_mask(len_code);
    end else if (wr_buf) begin
      shared_data_buffer <= reg_wdata;
    end
  end

  // received byte not yet read; survives run toggling
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unread <= 1'b0;
    end else if (rx_fetch) begin
      unread <= 1'b1;
    end else if (rd_buf) begin
      unread <= 1'b0;
    end
  end

  // status flags; hardware set wins over a status write
  always_ff @(posedge ref_clk) begin
    if (rst || direction_select) begin
      buffer_full_flag <= 1'b0;
    end else if (wr_buf) begin
      buffer_full_flag <= 1'b1;
    end else if (tx_load || wr_stat) begin
      buffer_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !direction_select) begin
      parity_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      frame_error_flag <= 1'b0;
    end else begin
      if (rx_check) begin
        parity_error_flag <= par_en && (rx_par_bit != par_of(rx_word, len_code, par_odd));
      end else if (wr_stat) begin
        parity_error_flag <= 1'b0;
      end
      if (rx_fetch && unread) begin
        overrun_error_flag <= 1'b1;
      end else if (wr_stat) begin
        overrun_error_flag <= 1'b0;
      end
      if (rx_check) begin
        frame_error_flag <= rx_start_err || !rx_line;
      end else if (rx_check2 && !rx_line) begin
        frame_error_flag <= 1'b1;
      end else if (wr_stat) begin
        frame_error_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= tx_load || tx_done || rx_check;
    end
  end

  always_comb begin
    stat_val = 8'h00;
    stat_val[`HDU_FER_BIT] = frame_error_flag;
    stat_val[`HDU_OER_BIT] = overrun_error_flag;
    stat_val[`HDU_PER_BIT] = parity_error_flag;
    stat_val[`HDU_FULL_BIT] = buffer_full_flag;
    next_rdata = 8'h00;
    unique case (reg_addr)
      `HDU_SETUP_ADDR: begin
        next_rdata[`HDU_DIR_BIT] = direction_select;
        next_rdata[`HDU_RSEL_BIT] = rx_pin_select;
        next_rdata[`HDU_RSS_BIT] = sample_shift_select;
        next_rdata[`HDU_CKS_LSB +: 2] = baud_clk_sel;
      end
      `HDU_FORMAT_ADDR: next_rdata = {1'b0, neg, msb_first, stop2, par_odd, par_en, len_code};
      `HDU_BAUD_LO_ADDR: next_rdata = baud_count[7:0];
      `HDU_BAUD_HI_ADDR: next_rdata = {4'h0, baud_count[11:8]};
      `HDU_CTRL_ADDR: next_rdata[`HDU_RUN_BIT] = channel_run;
      `HDU_BUF_ADDR: next_rdata = shared_data_buffer;
      `HDU_STAT_ADDR: next_rdata = stat_val;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_fer_tx_zero: assert property (!direction_select |=> !frame_error_flag)
    else $error("framing flag set in transmit mode");
  a_full_rx_zero: assert property (direction_select |=> !buffer_full_flag)
    else $error("full flag set in receive mode");
  a_rx_pin_high: assert property (direction_select |=> serial_out_pin)
    else $error("output pin not high in receive mode");
  a_full_on_write: assert property (wr_buf && !direction_select |=> buffer_full_flag)
    else $error("buffer write did not set full");
  a_start_irq: assert property (tx_load |=> irq_req ##1 (serial_out_pin == neg))
    else $error("start bit or its interrupt missing");
  a_tx_stop_run: assert property (tx_done |=> !channel_run && irq_req)
    else $error("transmit end did not clear run");
  a_overrun_set: assert property (rx_fetch && unread |=> overrun_error_flag)
    else $error("overrun not flagged");
  a_stat_clear: assert property (wr_stat && !rx_fetch && !rx_check && !rx_check2
    && !wr_buf |=> stat_val == 8'h00)
    else $error("status write left a flag set");
  a_idle_level: assert property (!direction_select && tx_state == hdu_pkg::tx_idle
    |=> serial_out_pin == !$past(neg))
    else $error("idle output not at stop level");
  c_tx_frame: cover property (tx_load ##[1:300] tx_done);
  c_rx_fetch: cover property (rx_fetch ##[1:300] rx_check);
  c_overrun: cover property (rx_fetch && unread);
endmodule

//--- verification/hdu_remote.sv
// Purpose: remote serial transceiver facing the channel pins
// Assumes: bench sets format byte and bit period between frames
// Notes: behavioural timing, bit period in ns
`timescale 1ns/1ps
`include "hdu_cfg.svh"
module hdu_remote (
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] f = 8'h00;
  int bit_ns = 200;
  logic listen = 1'b0;
  logic busy = 1'b0;
  logic bit_q = 1'b1;
  logic [7:0] got;
  logic got_par;
  logic got_stop;
  int n_got = 0;
  wire [3:0] len = 4'h5 + {2'b00, f[1:0]};
  wire pen = f[`HDU_PEN_BIT];
  wire odd = f[`HDU_PODD_BIT];
  wire stop2 = f[`HDU_STOP2_BIT];
  wire msb = f[`HDU_MSB_BIT];
  wire neg = f[`HDU_NEG_BIT];
  // idle at stop level of the chosen polarity
  assign line_out = busy ? bit_q ^ neg : ~neg;
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic p;
    p = odd ^ bad_par;
    busy = 1'b1;
    bit_q = 1'b0;
    #(bit_ns);
    for (int i = 0; i < len; i++) begin
      bit_q = msb ? d[len-1-i] : d[i];
      p = p ^ bit_q;
      #(bit_ns);
    end
    if (pen) begin
      bit_q = p;
      #(bit_ns);
    end
    bit_q = ~bad_stop;
    #(bit_ns);
    bit_q = 1'b1;
    if (stop2) begin
      #(bit_ns);
    end
    busy = 1'b0;
  endtask
  always begin
    wait (listen === 1'b1 && line_in === neg);
    #(bit_ns / 2);
    got = 8'h00;
    for (int i = 0; i < len; i++) begin
      #(bit_ns);
      if (msb) begin
        got[len-1-i] = line_in ^ neg;
      end else begin
        got[i] = line_in ^ neg;
      end
    end
    got_par = 1'b0;
    if (pen) begin
      #(bit_ns);
      got_par = line_in ^ neg;
    end
    #(bit_ns);
    got_stop = line_in ^ neg;
    if (stop2) begin
      #(bit_ns);
      got_stop = got_stop & (line_in ^ neg);
    end
    n_got++;
  end
endmodule

//--- verification/tb.sv
// Purpose: self-checking bench for the half-duplex channel
// Assumes: remote model on the pins, baud count set per test
// Notes: tx at 8 cycles a bit, rx at 16 cycles a bit
`timescale 1ns/1ps
`include "hdu_cfg.svh"
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic serial_out_pin;
  logic irq_req;
  logic line;
  logic use1 = 1'b0;
  logic neg_q = 1'b0;
  logic [7:0] f, d, m;
  int n;
  int n_fail = 0;
  int compares = 0;
  // unused receive pin rests at idle level
  wire pin0 = use1 ? ~neg_q : line;
  wire pin1 = use1 ? line : ~neg_q;
  hdu_channel i_hdu_channel (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_in_pin0(pin0), .serial_in_pin1(pin1), .serial_out_pin(serial_out_pin),
    .irq_req(irq_req));
  hdu_remote i_hdu_remote (.line_in(serial_out_pin), .line_out(line));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] dw);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dw;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(name, reg_rdata, exp);
  endtask
  task automatic wait_irq(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge ref_clk);
      if (irq_req === 1'b1) break;
    end
    chk("irq", {7'h00, i < lim}, 8'h01);
  endtask
  // listening is off while the line may change level
  task automatic fmt(input logic [7:0] fv, input int bns, input logic lis);
    i_hdu_remote.listen = 1'b0;
    wr(`HDU_FORMAT_ADDR, fv);
    i_hdu_remote.f = fv;
    i_hdu_remote.bit_ns = bns;
    neg_q <= fv[6];
    m = 8'hff >> (2'd3 - fv[1:0]);
    repeat (2) @(posedge ref_clk);
    i_hdu_remote.listen = lis;
  endtask
  task automatic rx_frame(input logic [7:0] dv, input logic [1:0] err, input logic rb,
      input logic [7:0] st);
    fork
      i_hdu_remote.send(dv, err[0], err[1]);
      wait_irq(400);
    join
    if (rb) begin
      rc(`HDU_BUF_ADDR, dv & m, "rx_word");
    end
    rc(`HDU_STAT_ADDR, st, "rx_stat");
  endtask
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    n_fail++;
    results();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rc(`HDU_BAUD_LO_ADDR, 8'hff, "baud_lo_rst");
    rc(`HDU_BAUD_HI_ADDR, 8'h0f, "baud_hi_rst");
    rc(`HDU_STAT_ADDR, 8'h00, "stat_rst");
    rc(3'h7, 8'h00, "unmapped");
    wr(`HDU_BAUD_LO_ADDR, 8'h07);
    wr(`HDU_BAUD_HI_ADDR, 8'h00);
    wr(`HDU_SETUP_ADDR, 8'h00);
    for (int k = 0; k < 8; k++) begin
      f = {1'b0, k[1] ^ k[2], k[2], k[0], k[1], k[2] | k[0], k[1:0]};
      d = 8'ha5 + 8'(k * 37);
      fmt(f, 200, 1'b1);
      wr(`HDU_BUF_ADDR, d);
      rc(`HDU_STAT_ADDR, 8'h08, "full_set");
      n = i_hdu_remote.n_got;
      wr(`HDU_CTRL_ADDR, 8'h01);
      wait_irq(10);
      rc(`HDU_STAT_ADDR, 8'h00, "full_clr");
      wait_irq(160);
      chk("tx_word", i_hdu_remote.got, d & m);
      chk("tx_par", {7'h00, i_hdu_remote.got_par}, {7'h00, f[2] & (f[3] ^ ^(d & m))});
      chk("tx_stop", {7'h00, i_hdu_remote.got_stop}, 8'h01);
      chk("tx_cnt", 8'(i_hdu_remote.n_got - n), 8'h01);
      rc(`HDU_CTRL_ADDR, 8'h00, "run_clr");
      chk("tx_idle", {7'h00, serial_out_pin}, {7'h00, ~f[6]});
    end
    fmt(8'h00, 200, 1'b1);
    n = i_hdu_remote.n_got;
    wr(`HDU_BUF_ADDR, 8'h96);
    wr(`HDU_CTRL_ADDR, 8'h01);
    wait_irq(10);
    wr(`HDU_BUF_ADDR, 8'h3b);
    rc(`HDU_STAT_ADDR, 8'h08, "full_b2b");
    wait_irq(160);
    rc(`HDU_CTRL_ADDR, 8'h01, "run_held");
    wait_irq(160);
    chk("b2b_word", i_hdu_remote.got, 8'h3b & m);
    chk("b2b_cnt", 8'(i_hdu_remote.n_got - n), 8'h02);
    wr(`HDU_SETUP_ADDR, 8'h01);
    wr(`HDU_BAUD_LO_ADDR, 8'h0f);
    fmt(8'h07, 400, 1'b0);
    wr(`HDU_CTRL_ADDR, 8'h01);
    chk("rx_out_high", {7'h00, serial_out_pin}, 8'h01);
    rx_frame(8'h3c, 2'b00, 1'b1, 8'h00);
    rx_frame(8'h5a, 2'b01, 1'b1, 8'h04);
    wr(`HDU_STAT_ADDR, 8'h5a);
    rc(`HDU_STAT_ADDR, 8'h00, "stat_clr");
    rx_frame(8'h81, 2'b10, 1'b1, 8'h01);
    rx_frame(8'h7e, 2'b00, 1'b0, 8'h00);
    wr(`HDU_CTRL_ADDR, 8'h00);
    wr(`HDU_CTRL_ADDR, 8'h01);
    rx_frame(8'h11, 2'b00, 1'b1, 8'h02);
    wr(`HDU_CTRL_ADDR, 8'h00);
    wr(`HDU_STAT_ADDR, 8'h00);
    wr(`HDU_SETUP_ADDR, 8'h17);
    wr(`HDU_BAUD_LO_ADDR, 8'h07);
    use1 <= 1'b1;
    fmt(8'h7d, 400, 1'b0);
    wr(`HDU_CTRL_ADDR, 8'h01);
    chk("rx_out_neg", {7'h00, serial_out_pin}, 8'h01);
    rx_frame(8'h2d, 2'b00, 1'b1, 8'h00);
    rx_frame(8'h15, 2'b01, 1'b1, 8'h04);
    results();
  end
endmodule
